// [rlm_consts.svh]
// Offsets, field positions, reset values and timing counts of the receive link error monitor.
`ifndef RLM_CONSTS_SVH
`define RLM_CONSTS_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define RLM_STATUS_OFS 8'h00
`define RLM_ENABLE_OFS 8'h04
`define RLM_CTRL_OFS 8'h08
`define RLM_LIVE_OFS 8'h0C
`define RLM_REINIT_CNT_OFS 8'h10

// ==========================================================================
// Error flag positions in the status and enable registers
`define RLM_NUM_ERR 10
`define RLM_BIT_EOEMB 0
`define RLM_BIT_CMD_PAR 1
`define RLM_BIT_CRC 2
`define RLM_BIT_UNDERRUN 3
`define RLM_BIT_OVERRUN 4
`define RLM_BIT_HDR_LOST 5
`define RLM_BIT_EMB_LOST 6
`define RLM_BIT_SKEW_FULL 7
`define RLM_BIT_ECC_CORR 8
`define RLM_BIT_ECC_FATAL 9

// ==========================================================================
// Control register fields and reset values
`define RLM_CTRL_CRC_REINIT 0
`define RLM_CTRL_SW_REINIT 1
`define RLM_CTRL_RST 1'h1
`define RLM_ENABLE_RST 10'h3FF

// ==========================================================================
// Link constants
`define RLM_EOEMB_ID 5'h01
`define RLM_CRC_W 12
`define RLM_CRC_POLY 12'h80F
`define RLM_CRC_INIT 12'h000
`define RLM_CNT_W 16

// ==========================================================================
// Timing
`define RLM_CLK_NS 40
`define RLM_REINIT_NS 400
`define RLM_REINIT_CYC ((`RLM_REINIT_NS + `RLM_CLK_NS - 1) / `RLM_CLK_NS)

`endif

// [rlm_crc_step.sv]
// Combinational CRC update of one received data word, most significant bit first.
`timescale 1ns/10ps
`include "rlm_consts.svh"

module rlm_crc_step
    import rlm_pkg::*;
#(
    parameter int DW = 64
) (
    // Running value in
    input wire logic [`RLM_CRC_W-1:0] crc_i,
    // Received word
    input wire logic [DW-1:0] data_i,
    // Updated value
    output logic [`RLM_CRC_W-1:0] crc_o
);

    // ======================================================================
    // Bit-serial division unrolled across the word
    always_comb begin
        logic fb;
        logic [`RLM_CRC_W-1:0] c;
        fb = 1'b0;
        c = crc_i;
        for (int i = DW - 1; i >= 0; i--) begin
            fb = c[`RLM_CRC_W-1] ^ data_i[i];
            c = {c[`RLM_CRC_W-2:0], 1'b0};
            if (fb) begin
                c = c ^ `RLM_CRC_POLY;
            end
        end
        crc_o = c;
    end

endmodule

// [rlm_monitor.sv]
// Receive link error monitor: error detection, sticky flags, interrupt and reinitialisation.
//
// Overview of operation
// - Flag an error when the end-of-extended-multiblock identifier has an unexpected value.
// - Per sync word, flag an error when command parity mismatches computed parity.
// - Flag an error when computed data CRC differs from CRC in sync word.
// - On a CRC error, reinitialise the link by itself; software checks persistence.
// - Flag underrun when any lane width converter FIFO underruns.
// - Flag overrun when any lane width converter overruns.
// - Link clock faster than 16:33 of PHY clock gives underrun; report it.
// - Link clock slower than 16:33 of PHY clock gives overrun; report it.
// - Flag loss of header alignment and always start reinitialisation.
// - Flag loss of extended multiblock alignment and always start reinitialisation.
// - Flag when a receive skew buffer fills, typically from excessive lane skew.
// - Flag corrected ECC events in one sticky bit; repeated events before a clear are not counted.
// - Flag a fatal ECC error when corrupted data was already forwarded.
`timescale 1ns/10ps
`include "rlm_consts.svh"

module rlm_monitor
    import rlm_pkg::*;
#(
    parameter int LANES = 4,
    parameter int DW = 64,
    parameter int CMD_W = 6
) (
    // Clock, reset and clock enable (clk_i is the receive link clock)
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,

    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,

    // Received data stream
    input wire logic data_valid_i,
    input wire logic [DW-1:0] data_i,
    input wire logic mb_end_i,

    // Sync word fields
    input wire logic syncword_valid_i,
    input wire logic [`RLM_CRC_W-1:0] sync_crc_i,
    input wire logic [CMD_W-1:0] cmd_bits_i,
    input wire logic cmd_parity_i,
    input wire logic eoemb_valid_i,
    input wire logic [4:0] eoemb_id_i,

    // Alignment and buffer status
    input wire logic header_lock_i,
    input wire logic emb_lock_i,
    input wire logic [LANES-1:0] skew_buffer_full_i,
    input wire logic ecc_corrected_i,
    input wire logic ecc_fatal_i,

    // Width converter status from the receive PHY clock domain
    input wire logic [LANES-1:0] width_converter_underrun_i,
    input wire logic [LANES-1:0] width_converter_overrun_i,

    // Outputs
    output logic reinit_o,
    output logic irq_o
);

    // ======================================================================
    // Constants
    localparam logic [7:0] REINIT_CYC = 8'(`RLM_REINIT_CYC);

    localparam rlm_state_t RST_STATE = '{
        status: '0,
        enable: `RLM_ENABLE_RST,
        crc_reinit_en: `RLM_CTRL_RST,
        rdata: '0,
        crc_acc: `RLM_CRC_INIT,
        crc_prev: `RLM_CRC_INIT,
        crc_prev_ok: 1'b0,
        hdr_lock_q: 1'b0,
        emb_lock_q: 1'b0,
        fsm: RLM_IDLE,
        reinit_left: '0,
        reinit_total: '0
    };

    // ======================================================================
    // State
    rlm_state_t r;
    rlm_state_t next_r;

    // ======================================================================
    // Width converter status crossing
    logic [LANES-1:0] underrun_s;
    logic [LANES-1:0] overrun_s;

    // The PHY clock is not related to the link clock, so both vectors go
    // through a plain two-stage synchroniser before any decision.
    rlm_sync2 #(
        .W(2 * LANES)
    ) u_gb_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .async_i({width_converter_overrun_i, width_converter_underrun_i}),
        .sync_o({overrun_s, underrun_s})
    );

    // ======================================================================
    // CRC over received data
    logic [`RLM_CRC_W-1:0] crc_step;

    rlm_crc_step #(
        .DW(DW)
    ) u_crc (
        .crc_i(r.crc_acc),
        .data_i(data_i),
        .crc_o(crc_step)
    );

    // ======================================================================
    // Error events of this cycle
    logic ev_eoemb;
    logic ev_cmd_par;
    logic ev_crc;
    logic ev_underrun;
    logic ev_overrun;
    logic ev_hdr_lost;
    logic ev_emb_lost;
    logic ev_skew_full;
    logic [`RLM_NUM_ERR-1:0] ev_vec;

    always_comb begin
        ev_eoemb = eoemb_valid_i && (eoemb_id_i != `RLM_EOEMB_ID);
        ev_cmd_par = syncword_valid_i && ((^cmd_bits_i) != cmd_parity_i);
        // A sync word checks the multiblock that completed before it.
        ev_crc = syncword_valid_i && r.crc_prev_ok && (sync_crc_i != r.crc_prev);
        ev_underrun = |underrun_s;
        ev_overrun = |overrun_s;
        ev_hdr_lost = r.hdr_lock_q && !header_lock_i;
        ev_emb_lost = r.emb_lock_q && !emb_lock_i;
        ev_skew_full = |skew_buffer_full_i;
        ev_vec = '0;
        ev_vec[`RLM_BIT_EOEMB] = ev_eoemb;
        ev_vec[`RLM_BIT_CMD_PAR] = ev_cmd_par;
        ev_vec[`RLM_BIT_CRC] = ev_crc;
        ev_vec[`RLM_BIT_UNDERRUN] = ev_underrun;
        ev_vec[`RLM_BIT_OVERRUN] = ev_overrun;
        ev_vec[`RLM_BIT_HDR_LOST] = ev_hdr_lost;
        ev_vec[`RLM_BIT_EMB_LOST] = ev_emb_lost;
        ev_vec[`RLM_BIT_SKEW_FULL] = ev_skew_full;
        ev_vec[`RLM_BIT_ECC_CORR] = ecc_corrected_i;
        ev_vec[`RLM_BIT_ECC_FATAL] = ecc_fatal_i;
    end

    // ======================================================================
    // Register port decode
    logic wr_status;
    logic wr_enable;
    logic wr_ctrl;
    logic sw_reinit;

    always_comb begin
        wr_status = 1'b0;
        wr_enable = 1'b0;
        wr_ctrl = 1'b0;
        if (wr_i && addr_i == `RLM_STATUS_OFS) begin
            wr_status = 1'b1;
        end else if (wr_i && addr_i == `RLM_ENABLE_OFS) begin
            wr_enable = 1'b1;
        end else if (wr_i && addr_i == `RLM_CTRL_OFS) begin
            wr_ctrl = 1'b1;
        end
        sw_reinit = wr_ctrl && wdata_i[`RLM_CTRL_SW_REINIT];
    end

    // ======================================================================
    // Reinitialisation triggers
    logic reinit_trig;

    always_comb begin
        reinit_trig = ev_hdr_lost || ev_emb_lost;
        if (ev_crc && r.crc_reinit_en) begin
            reinit_trig = 1'b1;
        end
        if (sw_reinit) begin
            reinit_trig = 1'b1;
        end
    end

    // ======================================================================
    // Next state
    always_comb begin
        next_r = r;

        // Lock levels are kept to find their falling edges and for the live register.
        next_r.hdr_lock_q = header_lock_i;
        next_r.emb_lock_q = emb_lock_i;

        // Running CRC of the current multiblock.
        if (data_valid_i) begin
            next_r.crc_acc = crc_step;
            if (mb_end_i) begin
                next_r.crc_prev = crc_step;
                next_r.crc_prev_ok = 1'b1;
                next_r.crc_acc = `RLM_CRC_INIT;
            end
        end

        // Losing header alignment makes the stored multiblock value stale.
        if (!header_lock_i) begin
            next_r.crc_prev_ok = 1'b0;
            next_r.crc_acc = `RLM_CRC_INIT;
        end

        // Sticky flags: a write of one clears, a new event in the same
        // cycle wins so that a clear never drops an error.
        if (wr_status) begin
            next_r.status = r.status & ~wdata_i[`RLM_NUM_ERR-1:0];
        end
        next_r.status = next_r.status | ev_vec;

        if (wr_enable) begin
            next_r.enable = wdata_i[`RLM_NUM_ERR-1:0];
        end
        if (wr_ctrl) begin
            next_r.crc_reinit_en = wdata_i[`RLM_CTRL_CRC_REINIT];
        end

        // Reinitialisation sequencer. While a request is already running,
        // further triggers are recorded in the flags but not repeated, which
        // avoids restarting the link over and over during its own relock.
        case (r.fsm)
            RLM_IDLE: begin
                if (reinit_trig) begin
                    next_r.fsm = RLM_REINIT;
                    next_r.reinit_left = REINIT_CYC - 8'h01;
                    if (r.reinit_total != '1) begin
                        next_r.reinit_total = r.reinit_total + `RLM_CNT_W'(1);
                    end
                end
            end
            RLM_REINIT: begin
                if (r.reinit_left == 8'h00) begin
                    next_r.fsm = RLM_HOLD;
                end else begin
                    next_r.reinit_left = r.reinit_left - 8'h01;
                end
            end
            RLM_HOLD: begin
                // Wait for both alignments to come back; software may force
                // another attempt if they never do.
                // An alignment that returns and drops again while the other
                // is still missing is a fresh loss, so it restarts the request.
                if (header_lock_i && emb_lock_i) begin
                    next_r.fsm = RLM_IDLE;
                end else if (sw_reinit || ev_hdr_lost || ev_emb_lost) begin
                    next_r.fsm = RLM_REINIT;
                    next_r.reinit_left = REINIT_CYC - 8'h01;
                    if (r.reinit_total != '1) begin
                        next_r.reinit_total = r.reinit_total + `RLM_CNT_W'(1);
                    end
                end
            end
            default: begin
                next_r.fsm = RLM_IDLE;
            end
        endcase

        if (wr_i && addr_i == `RLM_REINIT_CNT_OFS) begin
            next_r.reinit_total = '0;
        end

        // Read data stand only in the cycle after the strobe.
        next_r.rdata = '0;
        if (rd_i) begin
            if (addr_i == `RLM_STATUS_OFS) begin
                next_r.rdata = 32'(r.status);
            end else if (addr_i == `RLM_ENABLE_OFS) begin
                next_r.rdata = 32'(r.enable);
            end else if (addr_i == `RLM_CTRL_OFS) begin
                next_r.rdata = 32'(r.crc_reinit_en);
            end else if (addr_i == `RLM_LIVE_OFS) begin
                next_r.rdata = 32'({r.fsm, ev_skew_full, ev_overrun, ev_underrun,
                                    r.emb_lock_q, r.hdr_lock_q});
            end else if (addr_i == `RLM_REINIT_CNT_OFS) begin
                next_r.rdata = 32'(r.reinit_total);
            end
        end
    end

    // ======================================================================
    // State register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r <= RST_STATE;
        end else if (ce_i) begin
            r <= next_r;
        end
    end

    // ======================================================================
    // Outputs
    assign rdata_o = r.rdata;
    assign reinit_o = (r.fsm == RLM_REINIT);
    // Underrun and overrun only raise flags; recovery is left to the
    // controller, which must reset the receiver.
    assign irq_o = |(r.status & r.enable);

endmodule

// [rlm_monitor_sva.sv]
// Concurrent checks on the ports of the receive link error monitor.
`timescale 1ns/10ps

module rlm_monitor_sva #(
    parameter int LANES = 4,
    parameter int CMD_W = 6
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    // Link status
    input wire logic syncword_valid_i,
    input wire logic [CMD_W-1:0] cmd_bits_i,
    input wire logic cmd_parity_i,
    input wire logic eoemb_valid_i,
    input wire logic [4:0] eoemb_id_i,
    input wire logic header_lock_i,
    input wire logic emb_lock_i,
    input wire logic [LANES-1:0] skew_buffer_full_i,
    input wire logic [LANES-1:0] width_converter_underrun_i,
    // Outputs
    input wire logic reinit_o,
    input wire logic irq_o
);
    // ======================================================================
    // Shadow enable and settling counters
    logic [9:0] en;
    logic [1:0] up;
    logic [1:0] calm;
    logic quiet;

    // A write in the same cycle may mask or clear a flag, so checks skip it.
    assign quiet = ce_i && !wr_i && (up == 2'h3);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            en <= 10'h3FF;
            up <= 2'h0;
            calm <= 2'h0;
        end else begin
            if (up != 2'h3) begin
                up <= up + 2'h1;
            end
            if (ce_i && wr_i && addr_i == 8'h04) begin
                en <= wdata_i[9:0];
            end
            if (!(header_lock_i && emb_lock_i) || reinit_o) begin
                calm <= 2'h0;
            end else if (calm != 2'h3) begin
                calm <= calm + 2'h1;
            end
        end
    end

    // ======================================================================
    // Properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_eoemb_flag: assert property (quiet && eoemb_valid_i && eoemb_id_i != 5'h01 && en[0]
        |=> irq_o) else $error("bad pilot id not flagged");
    a_parity_flag: assert property (quiet && syncword_valid_i && en[1]
        && (cmd_parity_i != ^cmd_bits_i) |=> irq_o) else $error("parity error not flagged");
    a_hdr_reinit: assert property (quiet && calm == 2'h3 && !reinit_o && !header_lock_i
        |=> reinit_o) else $error("header loss gave no reinit");
    a_emb_reinit: assert property (quiet && calm == 2'h3 && !reinit_o && !emb_lock_i
        |=> reinit_o) else $error("multiblock loss gave no reinit");
    a_reinit_length: assert property ($rose(reinit_o)
        |-> reinit_o[*8] ##1 reinit_o[*2] ##1 !reinit_o) else $error("reinit length wrong");
    a_skew_flag: assert property (quiet && (|skew_buffer_full_i) && en[7]
        |=> irq_o) else $error("skew full not flagged");
    a_underrun_flag: assert property ((|width_converter_underrun_i)[*4] ##0 (quiet && en[3])
        |=> irq_o) else $error("underrun not flagged");
    a_irq_sticky: assert property (quiet && irq_o |=> irq_o)
        else $error("flag dropped without write");
    a_irq_masked: assert property (ce_i && wr_i && addr_i == 8'h04 && wdata_i[9:0] == 10'h000
        |=> !irq_o) else $error("irq with all masked");
endmodule

bind rlm_monitor rlm_monitor_sva #(.LANES(LANES), .CMD_W(CMD_W)) u_sva (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .syncword_valid_i(syncword_valid_i), .cmd_bits_i(cmd_bits_i),
    .cmd_parity_i(cmd_parity_i), .eoemb_valid_i(eoemb_valid_i), .eoemb_id_i(eoemb_id_i),
    .header_lock_i(header_lock_i), .emb_lock_i(emb_lock_i),
    .skew_buffer_full_i(skew_buffer_full_i),
    .width_converter_underrun_i(width_converter_underrun_i),
    .reinit_o(reinit_o), .irq_o(irq_o)
);

// [rlm_pkg.sv]
// Types shared by the receive link error monitor.
package rlm_pkg;
`include "rlm_consts.svh"

    // ======================================================================
    // Reinitialisation sequencer states
    typedef enum logic [1:0] {
        RLM_IDLE = 2'b00,
        RLM_REINIT = 2'b01,
        RLM_HOLD = 2'b10
    } rlm_fsm_t;

    // ======================================================================
    // Complete state of the monitor
    typedef struct packed {
        logic [`RLM_NUM_ERR-1:0] status;
        logic [`RLM_NUM_ERR-1:0] enable;
        logic crc_reinit_en;
        logic [31:0] rdata;
        logic [`RLM_CRC_W-1:0] crc_acc;
        logic [`RLM_CRC_W-1:0] crc_prev;
        logic crc_prev_ok;
        logic hdr_lock_q;
        logic emb_lock_q;
        rlm_fsm_t fsm;
        logic [7:0] reinit_left;
        logic [`RLM_CNT_W-1:0] reinit_total;
    } rlm_state_t;

endpackage

// [rlm_sync2.sv]
// Two-stage synchroniser for status levels made in another clock domain.
`timescale 1ns/10ps

module rlm_sync2 #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // Levels in and out
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    // ======================================================================
    // State
    typedef struct packed {
        logic [W-1:0] stage2;
        logic [W-1:0] stage1;
    } rlm_sync_state_t;

    rlm_sync_state_t r;
    rlm_sync_state_t next_r;

    // Only the second stage is read outside this process.
    always_comb begin
        next_r = r;
        next_r.stage1 = async_i;
        next_r.stage2 = r.stage1;
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r <= '0;
        end else if (ce_i) begin
            r <= next_r;
        end
    end

    assign sync_o = r.stage2;

endmodule

// [rlm_tx_model.sv]
// Behavioural far-end transmitter: one-word multiblocks, sync words and pilot ids.
`timescale 1ns/10ps

module rlm_tx_model #(
    parameter int DW = 64,
    parameter int CMD_W = 6
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Bench commands
    input wire logic go_i,
    input wire logic [2:0] fault_i,
    input wire logic [DW-1:0] word_i,
    input wire logic [CMD_W-1:0] cmd_i,
    // Link side
    output logic data_valid_o,
    output logic [DW-1:0] data_o,
    output logic mb_end_o,
    output logic sync_valid_o,
    output logic [11:0] sync_crc_o,
    output logic [CMD_W-1:0] cmd_bits_o,
    output logic cmd_parity_o,
    output logic [4:0] eoemb_id_o
);
    // ======================================================================
    // Framing
    logic [11:0] crc;
    logic [2:0] flt;

    function automatic logic [11:0] crc_of(input logic [DW-1:0] w);
        logic [11:0] c;
        c = 12'h000;
        for (int i = DW - 1; i >= 0; i--) begin
            c = {c[10:0], 1'b0} ^ ((c[11] ^ w[i]) ? 12'h80F : 12'h000);
        end
        return c;
    endfunction

    assign mb_end_o = data_valid_o;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            data_valid_o <= 1'b0;
            sync_valid_o <= 1'b0;
        end else begin
            data_valid_o <= go_i;
            sync_valid_o <= data_valid_o;
            // Idle lines toggle so a stale value can never pass for a real one.
            data_o <= go_i ? word_i : ~data_o;
            if (go_i) begin
                crc <= crc_of(word_i) ^ {11'h000, fault_i[2]};
                flt <= fault_i;
            end
            if (data_valid_o) begin
                sync_crc_o <= crc;
                cmd_bits_o <= cmd_i;
                cmd_parity_o <= (^cmd_i) ^ flt[1];
                eoemb_id_o <= flt[0] ? 5'h1E : 5'h01;
            end else begin
                sync_crc_o <= ~sync_crc_o;
                cmd_bits_o <= ~cmd_bits_o;
                cmd_parity_o <= ~cmd_parity_o;
                eoemb_id_o <= ~eoemb_id_o;
            end
        end
    end
endmodule

// [tb.sv]
// Self-checking testbench of the receive link error monitor.
`timescale 1ns/10ps

`define CHK(got, exp) begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("mismatch at %0t: got %h exp %h", $time, (got), (exp)); \
    end \
end

module tb;
    // ======================================================================
    // Signals
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic ce_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [9:0] evt = 10'h000;
    logic traffic = 1'b0;
    logic [63:0] word = 64'h0;
    logic [31:0] rnd = 32'h0;
    logic [31:0] seed = 32'h61;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    wire [31:0] rdata_o;
    wire reinit_o, irq_o, dv, mbe, sv, cp;
    wire [63:0] dat;
    wire [11:0] scrc;
    wire [5:0] cb;
    wire [4:0] eid;
    wire [3:0] lane = 4'h1 << rnd[7:6];
    wire go = (traffic & rnd[8]) | (|evt[2:0]);

    always #20 clk_i = ~clk_i;

    rlm_monitor dut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .data_valid_i(dv), .data_i(dat),
        .mb_end_i(mbe), .syncword_valid_i(sv), .sync_crc_i(scrc), .cmd_bits_i(cb),
        .cmd_parity_i(cp), .eoemb_valid_i(sv), .eoemb_id_i(eid), .header_lock_i(!evt[5]),
        .emb_lock_i(!evt[6]), .skew_buffer_full_i(evt[7] ? lane : 4'h0),
        .ecc_corrected_i(evt[8]), .ecc_fatal_i(evt[9]),
        .width_converter_underrun_i(evt[3] ? lane : 4'h0),
        .width_converter_overrun_i(evt[4] ? lane : 4'h0), .reinit_o(reinit_o), .irq_o(irq_o)
    );

    rlm_tx_model u_tx (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .go_i(go), .fault_i(evt[2:0]), .word_i(word),
        .cmd_i(rnd[5:0]), .data_valid_o(dv), .data_o(dat), .mb_end_o(mbe), .sync_valid_o(sv),
        .sync_crc_o(scrc), .cmd_bits_o(cb), .cmd_parity_o(cp), .eoemb_id_o(eid)
    );

    // ======================================================================
    // Helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Only flags 2, 5 and 6 start a reinitialisation.
    function automatic logic exp_reinit(input int k);
        return (k == 2) || (k == 5) || (k == 6);
    endfunction

    always @(posedge clk_i) begin
        word <= {xs(), xs()};
        rnd <= xs();
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    task automatic run_case(input int k);
        logic [31:0] d;
        @(posedge clk_i);
        evt <= 10'h001 << k;
        repeat (4) @(posedge clk_i);
        evt <= 10'h000;
        @(posedge clk_i);
        #1;
        `CHK(reinit_o, exp_reinit(k))
        repeat (20) @(posedge clk_i);
        rd(8'h00, d);
        `CHK(d, 32'h1 << k)
        `CHK(irq_o, 1'b1)
        wr(8'h00, 32'h1 << k);
        rd(8'h00, d);
        `CHK(d, 32'h0)
        `CHK(irq_o, 1'b0)
        $display("case %0d done", k);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ======================================================================
    // Main sequence
    initial begin
        logic [31:0] d;
        repeat (8) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(8'h00, d);
        `CHK(d, 32'h0)
        rd(8'h04, d);
        `CHK(d, 32'h3FF)
        rd(8'h08, d);
        `CHK(d, 32'h1)
        rd(8'h14, d);
        `CHK(d, 32'h0)
        @(posedge clk_i);
        traffic <= 1'b1;
        repeat (40) @(posedge clk_i);
        traffic <= 1'b0;
        repeat (4) @(posedge clk_i);
        rd(8'h00, d);
        `CHK(d, 32'h0)
        rd(8'h0C, d);
        `CHK(d, 32'h3)
        @(posedge clk_i);
        ce_i <= 1'b0;
        evt <= 10'h100;
        repeat (2) @(posedge clk_i);
        ce_i <= 1'b1;
        evt <= 10'h000;
        rd(8'h00, d);
        `CHK(d, 32'h0)
        $display("clean traffic done");
        for (int k = 0; k < 10; k++) begin
            run_case(k);
        end
        rd(8'h10, d);
        `CHK(d, 32'h3)
        wr(8'h08, 32'h3);
        #1;
        `CHK(reinit_o, 1'b1)
        repeat (12) @(posedge clk_i);
        rd(8'h10, d);
        `CHK(d, 32'h4)
        wr(8'h10, 32'h0);
        rd(8'h10, d);
        `CHK(d, 32'h0)
        $display("software reinit done");
        wr(8'h04, 32'h0);
        @(posedge clk_i);
        evt <= 10'h100;
        @(posedge clk_i);
        evt <= 10'h000;
        repeat (3) @(posedge clk_i);
        #1;
        `CHK(irq_o, 1'b0)
        wr(8'h04, 32'h3FF);
        #1;
        `CHK(irq_o, 1'b1)
        $display("masking done");
        @(posedge clk_i);
        evt <= 10'h210;
        repeat (6) @(posedge clk_i);
        rst_b_i <= 1'b0;
        evt <= 10'h000;
        repeat (8) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(8'h00, d);
        `CHK(d, 32'h0)
        $display("reset after overrun done");
        tally_and_finish();
    end
endmodule
